/* rtl/fcr_top.sv */
// Flash clock ratio, options and configuration registers on AHB-Lite
//
// Operation
// [R1] Ratio register bit 7 is read-only status; bits 6..0 take one write only.
// [R2] Ratio-loaded flag clears on reset, sets on first ratio write, any data.
// [R3] Program and erase are refused while ratio-loaded is 0, allowed once 1.
// [R4] Divider input is bus clock, or bus clock over 8 when prescale set.
// [R5] Timing clock is prescaler output divided by ratio field plus one.
// [R6] Each timing pulse is one timing clock; operations use whole pulses.
// [R7] Software keeps the timing clock between 150 kHz and 200 kHz.
// [R8] Stored options byte is copied into the options register at reset.
// [R9] Options bits 5..2 read 0; readable anytime; writes are ignored.
// [R10] With backdoor unlock enable 0 the key never disengages security.
// [R11] Eight in-order matching key bytes disengage security until next reset.
// [R12] Key compare writes only from secure firmware, never from debug.
// [R13] Redirect-disable 1 disables vector redirection; 0 enables it.
// [R14] Only security code 1:0 is unsecured; other three codes are secure.
// [R15] While secure, unsecured sources and debug cannot reach RAM or flash.
// [R16] Software should secure with code 0:1, two bit flips from unsecured.
// [R17] Config bits 7..5 read/write anytime; bits 4..0 read 0, ignore writes.
// [R18] Compare-key enable 1: key range writes compare; 0: they start commands.
// [R19] Clearing compare-key enable after eight matching bytes sets code 1:0.
// [R20] Command before ratio write raises access error and is ignored.
// [R21] Config writable bits, compare-key enable included, clear on reset.
`timescale 1ns/100ps
`default_nettype none
`include "fcr_params.svh"

module fcr_top #(
  parameter int OP_PULSES = `FCR_OP_PULSES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] stored_options_byte,
  input wire logic [63:0] stored_backdoor_key,
  input wire logic nvm_wr_valid,
  input wire logic [15:0] nvm_wr_addr,
  input wire logic [7:0] nvm_wr_data,
  input wire logic nvm_wr_secure_src,
  input wire logic nvm_wr_debug,
  output logic nvm_cmd_start,
  output logic nvm_busy,
  output logic nvm_timing_pulse,
  output logic access_error_flag,
  output logic secure_state,
  output logic mem_block_unsecured,
  output logic vector_redirect_enable
);

  // ************************************************************
  // Declarations
  // ************************************************************
  fcr_pkg::fcr_byte_t nvm_clock_ratio_reg, nvm_options_reg, nvm_config_reg;
  fcr_pkg::fcr_seq_t seq_state;
  logic ratio_loaded_flag, options_loaded, wr_pend, key_mismatch, unlocked;
  logic [7:0] wr_addr, key_byte, read_value;
  logic [2:0] prescale_cnt;
  logic [5:0] divider_cnt, clock_ratio_field;
  logic [15:0] pulse_cnt;
  logic [3:0] key_index;
  logic addr_ok, bus_wr, ratio_wr, config_wr, status_wr;
  logic compare_key_write_enable, eighth_prescale_select;
  logic backdoor_unlock_enable, is_secure, key_range, key_wr, cmd_wr;
  logic cmd_ok, cmd_err, prescale_tick, next_pulse, key_close, key_good;

  // Security decode: only 1:0 unsecured
  function automatic logic fcr_secure(input logic [1:0] code);
    fcr_secure = (code != `FCR_SEC_UNSECURED); // [R14]
  endfunction : fcr_secure

  // ************************************************************
  // Field views and decode
  // ************************************************************
  assign eighth_prescale_select = nvm_clock_ratio_reg[`FCR_RATIO_PRESCALE_BIT];
  assign clock_ratio_field = nvm_clock_ratio_reg[5:0];
  assign backdoor_unlock_enable = nvm_options_reg[`FCR_OPT_KEY_ENABLE_BIT];
  assign compare_key_write_enable = nvm_config_reg[`FCR_CFG_KEY_WRITE_BIT];
  assign is_secure = fcr_secure(nvm_options_reg[1:0]);
  assign addr_ok = hsel && hready && htrans[1];
  assign bus_wr = wr_pend;
  assign ratio_wr = bus_wr && (wr_addr == `FCR_OFS_RATIO);
  assign config_wr = bus_wr && (wr_addr == `FCR_OFS_CONFIG);
  assign status_wr = bus_wr && (wr_addr == `FCR_OFS_STATUS);

  // Writes into the backdoor key range
  assign key_range = (nvm_wr_addr[15:3] == 13'(`FCR_KEY_BASE >> 3));
  assign key_wr = nvm_wr_valid && key_range && compare_key_write_enable &&
                  nvm_wr_secure_src && !nvm_wr_debug; // [R12] [R18]
  assign cmd_wr = nvm_wr_valid &&
                  !(key_range && compare_key_write_enable); // [R18]
  assign cmd_ok = cmd_wr && ratio_loaded_flag &&
                  (seq_state == fcr_pkg::FCR_SEQ_IDLE); // [R3]
  assign cmd_err = cmd_wr && !cmd_ok; // [R20]
  assign key_byte = stored_backdoor_key[8 * key_index[2:0] +: 8];

  // Key check closes when software clears compare-key enable
  assign key_close = config_wr && compare_key_write_enable &&
                     !hwdata[`FCR_CFG_KEY_WRITE_BIT]; // [R19]
  assign key_good = key_close && backdoor_unlock_enable && !key_mismatch &&
                    (key_index == `FCR_KEY_BYTES); // [R10] [R11]

  // Timing clock: prescaler then divider
  assign prescale_tick = !eighth_prescale_select ||
                         (prescale_cnt == `FCR_PRESCALE_LAST); // [R4]
  assign next_pulse = ratio_loaded_flag && prescale_tick &&
                      (divider_cnt == clock_ratio_field); // [R5]

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  // Read mux, reserved bits read zero
  always_comb
  begin
    read_value = 8'h00;
    unique case (haddr[7:0])
      `FCR_OFS_RATIO: read_value = nvm_clock_ratio_reg;
      `FCR_OFS_OPTIONS:
        read_value = nvm_options_reg & `FCR_OPTIONS_MASK; // [R9]
      `FCR_OFS_CONFIG: read_value = nvm_config_reg & `FCR_CONFIG_MASK; // [R17]
      `FCR_OFS_STATUS:
      begin
        read_value[`FCR_STAT_SECURE_BIT] = is_secure;
        read_value[`FCR_STAT_BUSY_BIT] = (seq_state == fcr_pkg::FCR_SEQ_RUN);
        read_value[`FCR_STAT_UNLOCKED_BIT] = unlocked;
        read_value[`FCR_STAT_ACC_ERR_BIT] = access_error_flag;
      end
      default: read_value = 8'h00;
    endcase
    if (haddr[31:8] != 24'h000000)
    begin
      read_value = 8'h00;
    end
  end

  // Address phase capture; zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr <= haddr[7:0];
      hrdata <= (addr_ok && !hwrite) ? {24'h000000, read_value} : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Ratio register: one write, loaded flag set by it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nvm_clock_ratio_reg <= `FCR_RATIO_RESET;
      ratio_loaded_flag <= 1'b0; // [R2]
    end
    else if (ratio_wr && !ratio_loaded_flag)
    begin
      nvm_clock_ratio_reg <= {1'b1, hwdata[6:0]}; // [R1] [R2]
      ratio_loaded_flag <= 1'b1; // [R2]
    end
  end

  // Options copied once after reset; key match forces unsecured
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nvm_options_reg <= `FCR_OPTIONS_RESET;
      options_loaded <= 1'b0;
      unlocked <= 1'b0;
    end
    else if (!options_loaded)
    begin
      nvm_options_reg <= stored_options_byte & `FCR_OPTIONS_MASK; // [R8] [R9]
      options_loaded <= 1'b1;
    end
    else if (key_good)
    begin
      nvm_options_reg[1:0] <= `FCR_SEC_UNSECURED; // [R11] [R19]
      unlocked <= 1'b1;
    end
  end

  // Config register, cleared on every reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nvm_config_reg <= `FCR_CONFIG_RESET; // [R21]
    end
    else if (config_wr)
    begin
      nvm_config_reg <= hwdata[7:0] & `FCR_CONFIG_MASK; // [R17]
    end
  end

  // Access error: set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      access_error_flag <= 1'b0;
    end
    else if (cmd_err)
    begin
      access_error_flag <= 1'b1; // [R20]
    end
    else if (status_wr && hwdata[`FCR_STAT_ACC_ERR_BIT])
    begin
      access_error_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Backdoor key compare
  // ************************************************************
  // In-order byte tracking; restarts on every config register write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_index <= 4'h0;
      key_mismatch <= 1'b0;
    end
    else if (config_wr)
    begin
      key_index <= 4'h0;
      key_mismatch <= 1'b0;
    end
    else if (key_wr)
    begin
      if (key_index == `FCR_KEY_BYTES ||
          nvm_wr_addr[2:0] != key_index[2:0] ||
          nvm_wr_data != key_byte)
      begin
        key_mismatch <= 1'b1; // [R11]
      end
      if (key_index != `FCR_KEY_BYTES)
      begin
        key_index <= key_index + 4'h1;
      end
    end
  end

  // ************************************************************
  // Timing clock
  // ************************************************************
  // Prescaler by 8
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prescale_cnt <= 3'h0;
    end
    else
    begin
      prescale_cnt <= prescale_cnt + 3'h1; // [R4]
    end
  end

  // Divide by ratio field plus one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      divider_cnt <= 6'h00;
      nvm_timing_pulse <= 1'b0;
    end
    else
    begin
      nvm_timing_pulse <= next_pulse; // [R6]
      if (next_pulse)
      begin
        divider_cnt <= 6'h00;
      end
      else if (ratio_loaded_flag && prescale_tick)
      begin
        divider_cnt <= divider_cnt + 6'h01; // [R5]
      end
    end
  end

  // ************************************************************
  // Program and erase sequencer
  // ************************************************************
  // Runs a whole number of timing pulses per operation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq_state <= fcr_pkg::FCR_SEQ_IDLE;
      pulse_cnt <= 16'h0000;
      nvm_cmd_start <= 1'b0;
      nvm_busy <= 1'b0;
    end
    else
    begin
      nvm_cmd_start <= cmd_ok; // [R3]
      unique case (seq_state)
        fcr_pkg::FCR_SEQ_IDLE:
        begin
          if (cmd_ok)
          begin
            seq_state <= fcr_pkg::FCR_SEQ_RUN;
            pulse_cnt <= 16'h0000;
            nvm_busy <= 1'b1;
          end
        end
        fcr_pkg::FCR_SEQ_RUN:
        begin
          if (next_pulse)
          begin
            if (pulse_cnt == OP_PULSES[15:0] - 16'h0001)
            begin
              seq_state <= fcr_pkg::FCR_SEQ_IDLE; // [R6]
              nvm_busy <= 1'b0;
            end
            pulse_cnt <= pulse_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Security and redirect outputs
  // ************************************************************
  // Secure state, memory block and redirect flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      secure_state <= 1'b1;
      mem_block_unsecured <= 1'b1;
      vector_redirect_enable <= 1'b0;
    end
    else
    begin
      secure_state <= is_secure; // [R14]
      mem_block_unsecured <= is_secure; // [R15]
      vector_redirect_enable <=
        !nvm_options_reg[`FCR_OPT_REDIRECT_DIS_BIT]; // [R13]
    end
  end

endmodule : fcr_top

`default_nettype wire

/* rtl/fcr_params.svh */
// Offsets, field positions, reset values and counts of the flash control regs
`ifndef FCR_PARAMS_SVH
`define FCR_PARAMS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define FCR_OFS_RATIO 8'h00
`define FCR_OFS_OPTIONS 8'h04
`define FCR_OFS_CONFIG 8'h08
`define FCR_OFS_STATUS 8'h0C

// ************************************************************
// Field positions
// ************************************************************
`define FCR_RATIO_LOADED_BIT 7
`define FCR_RATIO_PRESCALE_BIT 6
`define FCR_OPT_KEY_ENABLE_BIT 7
`define FCR_OPT_REDIRECT_DIS_BIT 6
`define FCR_CFG_KEY_WRITE_BIT 5
`define FCR_STAT_SECURE_BIT 0
`define FCR_STAT_BUSY_BIT 1
`define FCR_STAT_UNLOCKED_BIT 2
`define FCR_STAT_ACC_ERR_BIT 4

// ************************************************************
// Reset values and masks
// ************************************************************
`define FCR_RATIO_RESET 8'h00
`define FCR_OPTIONS_RESET 8'hFF
`define FCR_OPTIONS_MASK 8'hC3
`define FCR_CONFIG_RESET 8'h00
`define FCR_CONFIG_MASK 8'hE0
`define FCR_SEC_UNSECURED 2'h2

// ************************************************************
// Key range and counts
// ************************************************************
`define FCR_KEY_BASE 16'hFFB0
`define FCR_KEY_BYTES 4'h8
`define FCR_PRESCALE_LAST 3'h7
`define FCR_OP_PULSES 16'h0004

`endif

/* rtl/fcr_pkg.sv */
// Types shared by the flash control register block
package fcr_pkg;

  // Program or erase sequencer states
  typedef enum logic [0:0] {
    FCR_SEQ_IDLE,
    FCR_SEQ_RUN
  } fcr_seq_t;

  // Byte register
  typedef logic [7:0] fcr_byte_t;

endpackage : fcr_pkg

/* tb/fcr_assertions.sv */
// Assertion checker bound to the flash control register block
`timescale 1ns/100ps
`default_nettype none
`include "fcr_params.svh"
module fcr_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] stored_options_byte,
  input wire logic nvm_wr_valid,
  input wire logic [15:0] nvm_wr_addr,
  input wire logic nvm_cmd_start,
  input wire logic nvm_busy,
  input wire logic nvm_timing_pulse,
  input wire logic access_error_flag,
  input wire logic secure_state,
  input wire logic mem_block_unsecured,
  input wire logic vector_redirect_enable
);
  // ****************************************
  // Helper state
  // ****************************************
  logic ph_rd, ph_wr, ph_ld, loaded, have_prev;
  logic [7:0] ph_addr;
  logic [6:0] ratio;
  logic [1:0] up;
  logic [9:0] gap;
  wire logic take = hsel && hready && htrans[1] && haddr[31:8] == 24'h0;
  wire logic cmd_wr = nvm_wr_valid && nvm_wr_addr[15:3] != 13'h1FF6;
  wire logic [9:0] per = (ratio[6] ? 10'h008 : 10'h001) *
    (10'h001 + {4'h0, ratio[5:0]});

  // Bus phases, first ratio write, age since reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_rd <= 1'b0;
      ph_wr <= 1'b0;
      ph_ld <= 1'b0;
      ph_addr <= 8'h00;
      loaded <= 1'b0;
      ratio <= 7'h00;
      up <= 2'h0;
    end
    else
    begin
      ph_rd <= take && !hwrite;
      ph_wr <= take && hwrite;
      ph_addr <= haddr[7:0];
      ph_ld <= loaded;
      if (up != 2'h2)
        up <= up + 2'h1;
      if (ph_wr && ph_addr == `FCR_OFS_RATIO && !loaded)
      begin
        loaded <= 1'b1;
        ratio <= hwdata[6:0];
      end
    end
  end

  // Cycles since last timing pulse inside one operation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap <= 10'h000;
      have_prev <= 1'b0;
    end
    else
    begin
      gap <= nvm_timing_pulse ? 10'h000 : gap + 10'h001;
      have_prev <= nvm_timing_pulse ? nvm_busy : have_prev && nvm_busy;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_REF: assert property (cmd_wr && !loaded |=>
    !nvm_cmd_start ##1 (access_error_flag && !nvm_cmd_start))
    else $error("cmd not refused");
  AST_GO: assert property (cmd_wr && loaded && !nvm_busy |->
    ##[1:2] nvm_cmd_start) else $error("cmd not started");
  AST_BUSY: assert property (nvm_cmd_start |-> ##[0:1] nvm_busy)
    else $error("no busy");
  AST_BLK: assert property (mem_block_unsecured == secure_state)
    else $error("block mismatch");
  AST_RATIO: assert property (
    ph_rd && ph_addr == `FCR_OFS_RATIO |-> hrdata[7] == ph_ld)
    else $error("loaded flag");
  AST_OPT: assert property (
    ph_rd && ph_addr == `FCR_OFS_OPTIONS |-> hrdata[5:2] == 4'h0)
    else $error("options spare bits");
  AST_CFG: assert property (
    ph_rd && ph_addr == `FCR_OFS_CONFIG |-> hrdata[4:0] == 5'h00)
    else $error("config spare bits");
  AST_PER: assert property (nvm_timing_pulse && have_prev |->
    gap == per - 10'h001) else $error("pulse period");
  AST_RED: assert property (up == 2'h2 |->
    vector_redirect_enable == !stored_options_byte[6])
    else $error("redirect");
  AST_SEC: assert property (
    up == 2'h2 && !stored_options_byte[7] |->
    secure_state == (stored_options_byte[1:0] != 2'h2)) else $error("secure");

  COV_GO: cover property (nvm_cmd_start);
  COV_UNL: cover property ($fell(secure_state));
  COV_ERR: cover property ($rose(access_error_flag));
endmodule : fcr_checker

bind fcr_top fcr_checker i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .stored_options_byte, .nvm_wr_valid, .nvm_wr_addr,
  .nvm_cmd_start, .nvm_busy, .nvm_timing_pulse, .access_error_flag,
  .secure_state, .mem_block_unsecured, .vector_redirect_enable
);
`default_nettype wire

/* tb/flash_control_registers_tb_top.sv */
// Self-checking bench for the flash control registers
`timescale 1ns/100ps
`default_nettype none
`include "fcr_params.svh"
module flash_control_registers_tb_top;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, nvm_wr_valid = 1'b0;
  logic nvm_wr_secure_src = 1'b0, nvm_wr_debug = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [15:0] nvm_wr_addr = 16'h0000;
  logic [7:0] nvm_wr_data = 8'h00, stored_options_byte = 8'hFF;
  logic hreadyout, nvm_cmd_start, nvm_busy, nvm_timing_pulse;
  logic access_error_flag, secure_state, mem_block_unsecured;
  logic vector_redirect_enable;
  int num_errors = 0, checked = 0, starts = 0, cycles = 0;

  fcr_top #(.OP_PULSES(3)) i_dut (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp(), .stored_options_byte, .stored_backdoor_key(KEY),
    .nvm_wr_valid, .nvm_wr_addr, .nvm_wr_data, .nvm_wr_secure_src,
    .nvm_wr_debug, .nvm_cmd_start, .nvm_busy, .nvm_timing_pulse,
    .access_error_flag, .secure_state, .mem_block_unsecured,
    .vector_redirect_enable
  );

  always #50 hclk = ~hclk;

  // Hang guard and command start count
  always @(posedge hclk)
  begin
    cycles++;
    if (nvm_cmd_start === 1'b1)
      starts++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report;
    end
  end

  task final_report;
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // One AHB-Lite single transfer, read data left in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, {24'h0, a}, {24'h0, d});
  endtask : wr

  task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, {24'h0, a}, 32'h0);
    chk(n, {24'h0, e}, rd);
  endtask : rdc

  // One write into flash space, from firmware or from debug
  task fw(input logic [15:0] a, input logic [7:0] d, input logic g);
    @(posedge hclk);
    nvm_wr_valid <= 1'b1;
    nvm_wr_addr <= a;
    nvm_wr_data <= d;
    nvm_wr_secure_src <= !g;
    nvm_wr_debug <= g;
    @(posedge hclk);
    nvm_wr_valid <= 1'b0;
  endtask : fw

  // Key entry; a stray byte goes in before byte bad
  task key_seq(input int bad, input logic g);
    wr(`FCR_OFS_CONFIG, 8'h20);
    for (int i = 0; i < 8; i++)
    begin
      if (i == bad)
        fw(16'hFFB0 + 16'(i), 8'h5A, g);
      fw(16'hFFB0 + 16'(i), KEY[8*i +: 8], 1'b0);
    end
    wr(`FCR_OFS_CONFIG, 8'h00);
    repeat (2) @(posedge hclk);
  endtask : key_seq

  task do_reset(input logic [7:0] opt);
    hresetn <= 1'b0;
    stored_options_byte <= opt;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : do_reset

  // Main sequence
  initial
  begin
    do_reset(8'hFF);
    rdc("opt", `FCR_OFS_OPTIONS, 8'hC3);
    wr(`FCR_OFS_OPTIONS, 8'h00);
    rdc("opt_ro", `FCR_OFS_OPTIONS, 8'hC3);
    rdc("ratio0", `FCR_OFS_RATIO, 8'h00);
    bus(1'b0, 32'h0000_0108, 32'h0);
    chk("unmap", 32'h0, rd);
    fw(16'hE000, 8'h55, 1'b0);
    repeat (2) @(posedge hclk);
    chk("err", 32'h1, {31'h0, access_error_flag});
    chk("nostart", 32'h0, 32'(starts));
    wr(`FCR_OFS_STATUS, 8'h10);
    wr(`FCR_OFS_CONFIG, 8'hFF);
    rdc("cfg", `FCR_OFS_CONFIG, 8'hE0);
    wr(`FCR_OFS_CONFIG, 8'h00);
    wr(`FCR_OFS_RATIO, 8'h46);
    rdc("ratio", `FCR_OFS_RATIO, 8'hC6);
    wr(`FCR_OFS_RATIO, 8'h05);
    rdc("ratio1", `FCR_OFS_RATIO, 8'hC6);
    fw(16'hFFB2, 8'hAA, 1'b0);
    repeat (2) @(posedge hclk);
    chk("start", 32'h1, 32'(starts));
    while (nvm_busy !== 1'b0)
      @(posedge hclk);
    key_seq(3, 1'b0);
    chk("badkey", 32'h1, {31'h0, secure_state});
    key_seq(5, 1'b1);
    chk("unlock", 32'h0, {31'h0, secure_state});
    chk("nocmd", 32'h1, 32'(starts));
    rdc("opt_unl", `FCR_OFS_OPTIONS, 8'hC2);
    for (int i = 0; i < 4; i++)
    begin
      do_reset({1'b0, i[0], 4'h0, i[1:0]});
      chk("sec", {31'h0, i != 2}, {31'h0, secure_state});
      chk("blk", {31'h0, i != 2}, {31'h0, mem_block_unsecured});
      chk("redir", {31'h0, !i[0]}, {31'h0, vector_redirect_enable});
      rdc("cfg0", `FCR_OFS_CONFIG, 8'h00);
      rdc("ratio_clr", `FCR_OFS_RATIO, 8'h00);
      wr(`FCR_OFS_CONFIG, 8'hE0);
    end
    key_seq(9, 1'b0);
    chk("keyoff", 32'h1, {31'h0, secure_state});
    wr(`FCR_OFS_RATIO, 8'h31);
    rdc("ratio_div1", `FCR_OFS_RATIO, 8'hB1);
    fw(16'hE000, 8'h00, 1'b0);
    repeat (2) @(posedge hclk);
    chk("start2", 32'h2, 32'(starts));
    while (nvm_busy !== 1'b0)
      @(posedge hclk);
    final_report;
  end
endmodule : flash_control_registers_tb_top
`default_nettype wire
